// [bench/pcc_array_sva.sv]
// Concurrent checks on module 0 of the capture/compare array, plus the irq gate across all five modules
`timescale 1ns/1ps
module pcc_array_sva (
    input wire clk,
    input wire rst_n,
    input wire [15:0] counter_value,
    input wire counter_tick,
    input wire [4:0] mode_wr,
    input wire [4:0] compare_low_wr,
    input wire [4:0] compare_high_wr,
    input wire [4:0] flag_clr,
    input wire array_irq_enable,
    input wire global_irq_enable,
    input wire [4:0] module_io_line_in,
    input wire [4:0] module_io_line_out,
    input wire [39:0] module_mode_rd,
    input wire [79:0] compare_word_rd,
    input wire [4:0] module_event_flag,
    input wire irq
);
    wire [7:0] m0 = module_mode_rd[7:0];
    wire [4:0] ie = {module_mode_rd[32], module_mode_rd[24], module_mode_rd[16],
        module_mode_rd[8], module_mode_rd[0]};
    // Software writes may override a hardware update
    wire q = !(mode_wr[0] | compare_low_wr[0] | compare_high_wr[0]);
    wire hit = counter_tick && q && counter_value == compare_word_rd[15:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rise;
        m0 == 8'h21 && $rose(module_io_line_in[0]);
    endsequence
    sequence s_flag_soon;
        ##[1:4] module_event_flag[0];
    endsequence
    a_irq_gate: assert property (irq == (|(module_event_flag & ie)
        && array_irq_enable && global_irq_enable)) else $error("irq gate");
    a_flag_sticky: assert property ($fell(module_event_flag[0])
        |-> $past(flag_clr[0])) else $error("flag dropped");
    a_low_clear: assert property (compare_low_wr[0] && !compare_high_wr[0]
        |=> !module_mode_rd[6]) else $error("low write");
    a_high_set: assert property (compare_high_wr[0] |=> module_mode_rd[6])
        else $error("high write");
    a_timer_flag: assert property (m0 == 8'h48 && hit |=> module_event_flag[0])
        else $error("timer flag");
    a_hs_toggle: assert property (m0 == 8'h4c && hit
        |=> module_io_line_out[0] != $past(module_io_line_out[0])) else $error("toggle");
    a_pulse_off: assert property ((m0 & 8'h76) == 8'h02 && q
        |=> !module_io_line_out[0]) else $error("pulse off");
    a_pwm16_high: assert property (m0 == 8'hc2 && hit |=> module_io_line_out[0])
        else $error("pulse16 rise");
    a_capture_rise: assert property (s_rise |-> s_flag_soon)
        else $error("capture flag");
endmodule // pcc_array_sva
bind pcc_array pcc_array_sva chk_u (.clk, .rst_n, .counter_value, .counter_tick, .mode_wr,
    .compare_low_wr, .compare_high_wr, .flag_clr, .array_irq_enable, .global_irq_enable,
    .module_io_line_in, .module_io_line_out, .module_mode_rd, .compare_word_rd,
    .module_event_flag, .irq);

// [bench/pcc_array_tb.sv]
// Self-checking bench for the capture/compare module array
`timescale 1ns/1ps
module pcc_array_tb;
    logic clk = 1'h0, rst_n = 1'h0, run_c = 1'h0, tk = 1'h0, lo = 1'h0, ov = 1'h0;
    logic ae = 1'h0, ge = 1'h0;
    logic [15:0] cv = 16'h0;
    logic [7:0] wd = 8'h0;
    logic [4:0] mw = 5'h0, lw = 5'h0, hw = 5'h0, fc = 5'h0, ext = 5'h0;
    wire [4:0] pin, io, oe, flag;
    wire [39:0] md;
    wire [79:0] wrd;
    wire [7:0] ctl;
    wire irq;
    int mismatches = 0, checks_done = 0, cyc = 0;
    pcc_array dut_u (.clk(clk), .rst_n(rst_n), .counter_value(cv), .counter_tick(tk),
        .counter_low_ovf(lo), .counter_ovf(ov), .counter_ovf_flag(ov), .counter_run(run_c),
        .mode_wr(mw), .mode_wdata(wd), .compare_low_wr(lw), .compare_high_wr(hw),
        .compare_wdata(wd), .flag_clr(fc), .array_irq_enable(ae), .global_irq_enable(ge),
        .module_io_line_in(pin), .module_io_line_out(io), .module_io_line_oe(oe),
        .module_mode_rd(md), .compare_word_rd(wrd), .module_event_flag(flag),
        .array_control_rd(ctl), .irq(irq));
    pcc_pin_model pin_u (.drv_out(io), .drv_oe(oe), .ext_level(ext), .pin_level(pin));
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        tk <= run_c;
        lo <= run_c && cv[7:0] == 8'hff;
        ov <= run_c && cv == 16'hffff;
        if (run_c) cv <= cv + 16'h1;
        if (cyc == 8000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic chk(input logic ok, input string s);
        checks_done++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge clk);
        wd <= d;
        {mw[0], lw[0], hw[0], fc[0]} <= 4'h8 >> k;
        @(posedge clk);
        {mw[0], lw[0], hw[0], fc[0]} <= 4'h0;
        #1;
    endtask
    task automatic run(input int n);
        @(posedge clk) run_c <= 1'h1;
        repeat (n) @(posedge clk);
        run_c <= 1'h0;
        wt(2);
    endtask
    task automatic hi(input int c, output int n);
        n = 0;
        repeat (c) begin
            @(posedge clk);
            #1 if (io[0] !== 1'h0) n++;
        end
    endtask
    task automatic pin0(input logic v);
        @(posedge clk) ext[0] <= v;
        wt(6);
    endtask
    task automatic t_cap;
        logic [7:0] m;
        for (int i = 0; i < 3; i++) begin
            m = i == 0 ? 8'h21 : i == 1 ? 8'h11 : 8'h31;
            @(posedge clk) cv <= 16'h1230 + 16'(i);
            wr(0, m);
            wr(3, 8'h0);
            pin0(1'h1);
            chk(flag[0] === m[5], "rise");
            if (m[5]) chk(wrd[15:0] === 16'h1230 + 16'(i), "value");
            for (int j = 0; j < 4 && i == 0; j++) begin
                @(posedge clk) {ge, ae} <= 2'(j);
                wt(1);
                chk(irq === (j == 3), "irq");
            end
            chk(flag[0] === m[5] && ctl === {ov, run_c, 1'h0, 4'h0, m[5]}, "held");
            wr(3, 8'h0);
            pin0(1'h0);
            chk(flag[0] === m[4], "fall");
        end
    endtask
    task automatic t_tmr;
        logic o;
        wr(0, 8'h48);
        wr(1, 8'h10);
        chk(md[6] === 1'h0, "low write");
        wr(2, 8'h0);
        chk(md[6] === 1'h1 && wrd[15:0] === 16'h0010, "high write");
        wr(3, 8'h0);
        @(posedge clk) cv <= 16'h0008;
        run(4);
        chk(flag[0] === 1'h0, "early");
        run(6);
        chk(flag[0] === 1'h1, "timer");
        wr(0, 8'h68);
        wr(3, 8'h0);
        pin0(1'h1);
        chk(flag[0] === 1'h0 && wrd[15:0] === 16'h0010, "no capture");
        @(posedge clk) cv <= 16'h000c;
        run(6);
        chk(flag[0] === 1'h1 && io[0] === 1'h0 && oe[0] === 1'h0, "odd match");
        pin0(1'h0);
        wr(0, 8'h4c);
        o = io[0];
        @(posedge clk) cv <= 16'h000c;
        run(6);
        chk(io[0] === ~o && oe[0] === 1'h1, "toggle");
    endtask
    task automatic t_freq;
        logic o;
        wr(0, 8'h46);
        wr(1, 8'h08);
        wr(2, 8'h04);
        wr(3, 8'h0);
        o = io[0];
        @(posedge clk) cv <= 16'h0;
        run(18);
        chk(wrd[15:0] === 16'h0414 && io[0] === ~o && flag[0] === 1'h1, "freq");
    endtask
    task automatic t_pwm;
        int n;
        for (int k = 0; k < 3; k++) begin
            if (k < 2) wr(0, 8'h42);
            wr(k < 2 ? 2 : 1, k == 0 ? 8'hc0 : 8'h0);
            @(posedge clk) run_c <= 1'h1;
            wt(300);
            hi(256, n);
            @(posedge clk) run_c <= 1'h0;
            chk(n == (k == 0 ? 64 : k == 1 ? 256 : 0), "pulse8");
        end
        wr(0, 8'hc2);
        wr(1, 8'hf0);
        wr(2, 8'hff);
        @(posedge clk) begin
            cv <= 16'hffe0;
            run_c <= 1'h1;
        end
        hi(96, n);
        @(posedge clk) run_c <= 1'h0;
        chk(n == 16, "pulse16");
        wr(0, 8'hcb);
        wr(3, 8'h0);
        @(posedge clk) cv <= 16'hffe0;
        run(20);
        chk(flag[0] === 1'h1 && irq === 1'h1, "match flag");
        wr(3, 8'h0);
        wr(1, 8'hd0);
        wr(2, 8'hff);
        @(posedge clk) begin
            cv <= 16'hffc0;
            run_c <= 1'h1;
        end
        hi(96, n);
        @(posedge clk) run_c <= 1'h0;
        chk(n == 48 && flag[0] === 1'h1, "pulse16 update");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        wt(1);
        chk(io === 5'h0 && oe === 5'h0 && flag === 5'h0 && irq === 1'h0, "reset");
        chk(md === 40'h0 && wrd === 80'h0, "reset regs");
        t_cap();
        t_tmr();
        t_freq();
        t_pwm();
        stop_test();
    end
endmodule // pcc_array_tb

// [bench/pcc_pin_model.sv]
// Far side of the five module I/O lines
`timescale 1ns/1ps
module pcc_pin_model (
    input wire [4:0] drv_out,
    input wire [4:0] drv_oe,
    input wire [4:0] ext_level,
    output wire [4:0] pin_level
);
    // Released lines follow the outside source, never a stale module value
    assign pin_level = (drv_oe & drv_out) | (~drv_oe & ext_level);
endmodule // pcc_pin_model

// [hw/pcc_array.v]
// Five capture/compare modules watching one shared 16-bit counter
`timescale 1ns/1ps
`include "pcc_map.vh"
module pcc_array (
    input wire clk,
    input wire rst_n,
    input wire [15:0] counter_value,
    input wire counter_tick,
    input wire counter_low_ovf,
    input wire counter_ovf,
    input wire counter_ovf_flag,
    input wire counter_run,
    input wire [4:0] mode_wr,
    input wire [7:0] mode_wdata,
    input wire [4:0] compare_low_wr,
    input wire [4:0] compare_high_wr,
    input wire [7:0] compare_wdata,
    input wire [4:0] flag_clr,
    input wire array_irq_enable,
    input wire global_irq_enable,
    input wire [4:0] module_io_line_in,
    output wire [4:0] module_io_line_out,
    output wire [4:0] module_io_line_oe,
    output wire [39:0] module_mode_rd,
    output wire [79:0] compare_word_rd,
    output wire [4:0] module_event_flag,
    output wire [7:0] array_control_rd,
    output wire irq
);

// Mode decode from the eight mode bits
// Unlisted combinations fall through to no mode
function [2:0] pcc_decode;
    input [7:0] m;
    reg caps;
    begin
        caps = m[`PCC_RISE_CAP] | m[`PCC_FALL_CAP];
        pcc_decode = `PCC_MD_NONE;
        if (caps && !m[`PCC_MATCH_EN] && !m[`PCC_TOGGLE_EN] && !m[`PCC_PULSE_EN]) begin
            pcc_decode = `PCC_MD_CAPTURE;
        end else if (!caps && m[`PCC_PULSE_EN] && !m[`PCC_TOGGLE_EN]) begin
            // Pulse modes decode regardless of compare enable so it can force low
            // wide select picks sixteen bits
            if (m[`PCC_WIDE_PULSE]) begin
                pcc_decode = `PCC_MD_PULSE16;
            end else begin
                pcc_decode = `PCC_MD_PULSE8;
            end
        end else if (!caps && m[`PCC_COMPARE_EN]) begin
            if (m[`PCC_PULSE_EN] && m[`PCC_TOGGLE_EN]) begin
                pcc_decode = `PCC_MD_FREQ_OUT;
            end else if (m[`PCC_MATCH_EN] && m[`PCC_TOGGLE_EN]) begin
                pcc_decode = `PCC_MD_HS_OUT;
            end else if (m[`PCC_MATCH_EN] && !m[`PCC_TOGGLE_EN]) begin
                pcc_decode = `PCC_MD_SW_TIMER;
            end
        end
    end
endfunction

// Modes in which the module drives its I/O line
// Pulse modes drive even with compare off, so the pin never floats
function pcc_drives;
    input [2:0] md;
    begin
        pcc_drives = (md == `PCC_MD_HS_OUT) || (md == `PCC_MD_FREQ_OUT) ||
                     (md == `PCC_MD_PULSE8) || (md == `PCC_MD_PULSE16);
    end
endfunction

wire [4:0] edge_rise;
wire [4:0] edge_fall;

genvar gi;
generate
for (gi = 0; gi < `PCC_NUM_MOD; gi = gi + 1) begin : g_mod

    reg [7:0] mode_q;
    reg [7:0] mode_d;
    reg [7:0] cmp_lo_q;
    reg [7:0] cmp_lo_d;
    reg [7:0] cmp_hi_q;
    reg [7:0] cmp_hi_d;
    reg io_q;
    reg io_d;
    reg flag_q;
    reg flag_d;
    reg event_set;

    wire [2:0] md;
    wire compare_en;
    wire match_en;
    wire [7:0] lo_eff;
    wire hit16;
    wire hit8;
    wire cap_ev;
    wire is_cap;
    wire is_freq;
    wire is_pulse8;
    wire [15:0] cmp_word;
    wire [7:0] freq_next;

    // line synchronised before edges are seen
    pcc_edge_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(module_io_line_in[gi]),
        .rise(edge_rise[gi]),
        .fall(edge_fall[gi])
    );

    // each slice decodes its own bits
    assign md = pcc_decode(mode_q);
    assign compare_en = mode_q[`PCC_COMPARE_EN];
    assign match_en = mode_q[`PCC_MATCH_EN];

    // Shared mode tests, so every process agrees on the decode
    assign is_cap = (md == `PCC_MD_CAPTURE);
    assign is_freq = (md == `PCC_MD_FREQ_OUT);
    assign is_pulse8 = (md == `PCC_MD_PULSE8);
    assign cmp_word = {cmp_hi_q, cmp_lo_q};

    // next toggle point wraps like the counter low byte
    assign freq_next = cmp_lo_q + cmp_hi_q;

    // rollover uses the reloaded byte in the same cycle
    // reload makes high time 256 minus high byte
    assign lo_eff = (is_pulse8 && counter_low_ovf) ? cmp_hi_q : cmp_lo_q;
    // Compares only on a counter step, so a held count matches once
    assign hit16 = counter_tick && (counter_value == cmp_word);
    assign hit8 = counter_tick && (counter_value[7:0] == lo_eff);

    // edge selection by rise and fall bits
    assign cap_ev = is_cap &&
                    ((mode_q[`PCC_RISE_CAP] && edge_rise[gi]) ||
                     (mode_q[`PCC_FALL_CAP] && edge_fall[gi]));

    // Event that sets the module flag
    always @* begin
        event_set = 1'b0;
        case (md)
            `PCC_MD_CAPTURE: begin
                event_set = cap_ev;
            end
            `PCC_MD_SW_TIMER: begin
                event_set = hit16;
            end
            `PCC_MD_HS_OUT: begin
                // match enable is set here too
                event_set = hit16;
            end
            `PCC_MD_FREQ_OUT: begin
                // flag on each toggle, twice the wave rate
                event_set = hit8;
            end
            `PCC_MD_PULSE8: begin
                event_set = compare_en && match_en && hit8;
            end
            `PCC_MD_PULSE16: begin
                event_set = compare_en && match_en && hit16;
            end
            default: begin
                // undefined combos flag only on enabled match
                event_set = compare_en && match_en && hit16;
            end
        endcase
    end

    // Mode register and compare enable side effects
    always @* begin
        mode_d = mode_q;
        if (mode_wr[gi]) begin
            mode_d = mode_wdata;
        end
        // A mode write loses bit 6 to a byte write in the same cycle
        // byte writes steer compare enable, high byte last wins
        if (compare_low_wr[gi]) begin
            mode_d[`PCC_COMPARE_EN] = 1'b0;
        end
        if (compare_high_wr[gi]) begin
            mode_d[`PCC_COMPARE_EN] = 1'b1;
        end
    end

    // Low compare byte: software write beats hardware update
    always @* begin
        cmp_lo_d = cmp_lo_q;
        if (compare_low_wr[gi]) begin
            cmp_lo_d = compare_wdata;
        end else if (cap_ev) begin
            // low byte of the captured count
            cmp_lo_d = counter_value[7:0];
        end else if (is_freq && compare_en && hit8) begin
            // advance the next toggle point by the high byte
            // A high byte of zero keeps one toggle per 256 counts
            cmp_lo_d = freq_next;
        end else if (is_pulse8 && counter_low_ovf) begin
            // reload from own high byte on low-byte rollover
            cmp_lo_d = cmp_hi_q;
        end
    end

    // High compare byte
    always @* begin
        cmp_hi_d = cmp_hi_q;
        if (compare_high_wr[gi]) begin
            cmp_hi_d = compare_wdata;
        end else if (cap_ev) begin
            // high byte of the captured count
            cmp_hi_d = counter_value[15:8];
        end
    end

    // Output line behaviour per mode
    always @* begin
        io_d = io_q;
        case (md)
            `PCC_MD_HS_OUT: begin
                if (hit16) begin
                    io_d = ~io_q;
                end
            end
            `PCC_MD_FREQ_OUT: begin
                // match enable plays no part here
                if (hit8) begin
                    io_d = ~io_q;
                end
            end
            `PCC_MD_PULSE8: begin
                // compare enable clear forces zero duty
                if (!compare_en) begin
                    io_d = 1'b0;
                // match wins over rollover, giving full duty at zero
                end else if (hit8) begin
                    io_d = 1'b1;
                end else if (counter_low_ovf) begin
                    io_d = 1'b0;
                end
            end
            `PCC_MD_PULSE16: begin
                // compare enable clear forces zero duty
                if (!compare_en) begin
                    io_d = 1'b0;
                // high at match, low at 16-bit overflow
                end else if (hit16) begin
                    io_d = 1'b1;
                end else if (counter_ovf) begin
                    io_d = 1'b0;
                end
            end
            default: begin
                io_d = io_q;
            end
        endcase
    end

    // only software clears, and a new event beats the clear
    always @* begin
        flag_d = (flag_q & ~flag_clr[gi]) | event_set;
    end

    // Configuration bytes and mode
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= `PCC_MODE_RST;
            cmp_lo_q <= `PCC_CMP_RST;
            cmp_hi_q <= `PCC_CMP_RST;
        end else begin
            mode_q <= mode_d;
            cmp_lo_q <= cmp_lo_d;
            cmp_hi_q <= cmp_hi_d;
        end
    end

    // Line and flag; reset leaves the line low and undriven
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_q <= `PCC_IO_RST;
            flag_q <= `PCC_FLAG_RST;
        end else begin
            io_q <= io_d;
            flag_q <= flag_d;
        end
    end

    assign module_io_line_out[gi] = io_q;
    assign module_io_line_oe[gi] = pcc_drives(md);
    assign module_mode_rd[gi*8 +: 8] = mode_q;
    assign compare_word_rd[gi*16 +: 16] = cmp_word;
    assign module_event_flag[gi] = flag_q;

end
endgenerate

// Per-module flag interrupt enables gathered for the request
wire [4:0] flag_irq_enable;
generate
for (gi = 0; gi < `PCC_NUM_MOD; gi = gi + 1) begin : g_en
    assign flag_irq_enable[gi] = module_mode_rd[gi*8 + `PCC_FLAG_IRQ_EN];
end
endgenerate

// request needs all three enable levels
// any enabled flag raises it
// Level request; stays up until software clears the flag
assign irq = global_irq_enable && array_irq_enable &&
             (|(module_event_flag & flag_irq_enable));

// flags in bits 4..0 beside overflow flag and run bit
assign array_control_rd[`PCC_CTL_OVF_FLAG] = counter_ovf_flag;
assign array_control_rd[`PCC_CTL_RUN] = counter_run;
assign array_control_rd[`PCC_CTL_UNUSED] = 1'b0;
assign array_control_rd[`PCC_CTL_FLAG_HI:`PCC_CTL_FLAG_LO] = module_event_flag;

endmodule // pcc_array

// [hw/pcc_edge_sync.v]
// Two-flop synchroniser and edge detector for one module I/O line
`timescale 1ns/1ps
module pcc_edge_sync (
    input wire clk,
    input wire rst_n,
    input wire pin_in,
    output wire rise,
    output wire fall
);

reg meta_q;
reg sync_q;
reg last_q;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        last_q <= 1'b0;
    end else begin
        meta_q <= pin_in;
        sync_q <= meta_q;
        last_q <= sync_q;
    end
end

// Edges seen only after the second flop, one pulse per transition
assign rise = sync_q & ~last_q;
assign fall = ~sync_q & last_q;

endmodule // pcc_edge_sync

// [hw/pcc_map.vh]
// Constants for the capture/compare module array: fields, mode codes, resets
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

// Number of capture/compare modules sharing the counter
`define PCC_NUM_MOD 5

// Field positions in module_mode_reg
`define PCC_WIDE_PULSE 7
`define PCC_COMPARE_EN 6
`define PCC_RISE_CAP 5
`define PCC_FALL_CAP 4
`define PCC_MATCH_EN 3
`define PCC_TOGGLE_EN 2
`define PCC_PULSE_EN 1
`define PCC_FLAG_IRQ_EN 0

// Field positions in array_control_reg
`define PCC_CTL_OVF_FLAG 7
`define PCC_CTL_RUN 6
`define PCC_CTL_UNUSED 5
`define PCC_CTL_FLAG_HI 4
`define PCC_CTL_FLAG_LO 0

// Reset values
`define PCC_MODE_RST 8'h00
`define PCC_CMP_RST 8'h00
`define PCC_IO_RST 1'b0
`define PCC_FLAG_RST 1'b0

// Decoded operating modes
`define PCC_MD_NONE 3'h0
`define PCC_MD_CAPTURE 3'h1
`define PCC_MD_SW_TIMER 3'h2
`define PCC_MD_HS_OUT 3'h3
`define PCC_MD_FREQ_OUT 3'h4
`define PCC_MD_PULSE8 3'h5
`define PCC_MD_PULSE16 3'h6

`endif
